// ===== rtl/psfm_pkg.sv
package psfm_pkg;
// What this block does
// [RULE_01] any fault tri-states affected half-bridges, pulls flag low; a stuck PWM input stops its group here without pulling the flag
// [RULE_02] faults other than overload and thermal clear themselves when gone
// [RULE_03] A/B faults stop A+B, C/D stop C+D; parallel stops all four
// [RULE_04] bootstrap low turns off only that high side, no flag
// [RULE_05] pin short check runs once at supply power-up only
// [RULE_06] shorts found keep all bridges off; removal resumes start-up
// [RULE_07] check tests ground shorts first, then stage supply shorts
// [RULE_08] flag held low and reset pin ignored during the check
// [RULE_09] toggling the reset pin never starts a new check
// [RULE_10] check skipped in single-ended output configuration
// [RULE_11] warning output low above warning level, switching continues
// [RULE_12] over shutdown level: latched, all bridges off, flag low
// [RULE_13] thermal latch cleared only by the reset pin held low
// [RULE_14] power-up clears overload latch and holds until supplies are up
// [RULE_15] common or gate supply low: all off, flag low, self clearing
// [RULE_16] reset pin low forces the shutdown flag high
// [RULE_17] flag and warning are active-low open-drain outputs
// [RULE_18] flag/warning pair encodes thermal, overload/supply, warning, normal
// [RULE_19] global fault stops all switching, latched until reset toggle
// [RULE_20] channel fault stops only the affected channel group
// [RULE_21] controller releases reset only while warning is high
// [RULE_22] controller reduces dissipation on warning; psfm_ctrl takes no such action
// [RULE_23] controller waits 4 ms after flag fall before reset rise; psfm_ctrl waits HOLD_CYC clock cycles instead
// [RULE_24] reset pin low holds every half-bridge transistor off
// [RULE_25] missing input PWM is a self-clearing channel stop
// [RULE_26] comparator inputs pass two flip-flops before use

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] CONFIG_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [1:0] MODE_BRIDGED = 2'h0;
  localparam logic [1:0] MODE_PARALLEL = 2'h1;
  localparam logic [1:0] MODE_SINGLE = 2'h2;
  localparam logic [1:0] CONFIG_RESET = 2'h0;

  // status word layout
  localparam int ST_FAULT = 0;
  localparam int ST_WARN = 1;
  localparam int ST_THERM = 2;
  localparam int ST_SUPLOW = 3;
  localparam int ST_OVL = 4;
  localparam int ST_STUCK = 8;
  localparam int ST_BRIDGE = 12;
  localparam int ST_BOOT = 16;
  localparam int ST_PHASE = 20;
  localparam int ST_FLAG_PIN = 24;
  localparam int ST_WARN_PIN = 25;

  // ----------------------------------------------------------------
  // synchronised input vector layout
  // ----------------------------------------------------------------
  localparam int IN_RST = 0;
  localparam int IN_WARN = 1;
  localparam int IN_SHUT = 2;
  localparam int IN_SUP = 3;
  localparam int IN_GSHORT = 6;
  localparam int IN_PSHORT = 7;
  localparam int IN_BOOT = 8;
  localparam int IN_OVL = 12;
  localparam int IN_STUCK = 16;
  localparam int IN_FLAG_PIN = 20;
  localparam int IN_WARN_PIN = 21;
  localparam int IN_W = 22;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ = 25_000_000;
  localparam longint PSC_MS_PER_UF = 15;
  localparam int FILTER_CAP_NF_DEF = 1000;

  // one of the two check steps, longest time so rounded down
  function automatic int psc_step_cycles(input int cap_nf);
    longint c;
    c = CLK_HZ / 1000 * PSC_MS_PER_UF * longint'(cap_nf) / 1000 / 2;
    return (c < 1) ? 1 : int'(c);
  endfunction : psc_step_cycles

  typedef enum logic [3:0] {
    PH_POWERUP = 4'h1,
    PH_GND = 4'h2,
    PH_SUPPLY = 4'h4,
    PH_RUN = 4'h8
  } psfm_phase_type;

endpackage : psfm_pkg

// ===== rtl/psfm_top.sv
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ns
module psfm_top #(
  parameter int STEP_CYCLES =
    psfm_pkg::psc_step_cycles(psfm_pkg::FILTER_CAP_NF_DEF)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [psfm_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reset_pin_n,
  input wire logic ot_warn_cmp,
  input wire logic ot_shut_cmp,
  input wire logic [2:0] supply_low_cmp,
  input wire logic short_gnd_cmp,
  input wire logic short_sup_cmp,
  input wire logic [3:0] boot_low_cmp,
  input wire logic [3:0] overload_cmp,
  input wire logic [3:0] pwm_stuck_cmp,
  output logic [3:0] bridge_en,
  output logic [3:0] high_side_en,
  output logic test_gnd_en,
  output logic test_sup_en,
  input wire logic shutdown_flag_n_i,
  output logic shutdown_flag_n_o,
  output logic shutdown_flag_n_oe,
  input wire logic temp_warning_n_i,
  output logic temp_warning_n_o,
  output logic temp_warning_n_oe
);

  localparam int CNT_W = $clog2(STEP_CYCLES + 1);
  localparam logic [CNT_W-1:0] STEP_LAST = CNT_W'(STEP_CYCLES - 1);
  // supplies read as low until really sampled: no early check start
  localparam logic [psfm_pkg::IN_W-1:0] SYNC_INIT =
    {{(psfm_pkg::IN_W - psfm_pkg::IN_SUP - 3){1'b0}}, 3'h7,
     {psfm_pkg::IN_SUP{1'b0}}};

  generate
    if (STEP_CYCLES < 1) begin : g_bad_step
      $error("STEP_CYCLES must be at least one");
    end
  endgenerate

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [psfm_pkg::IN_W-1:0] sync1;
    logic [psfm_pkg::IN_W-1:0] sync2;
    psfm_pkg::psfm_phase_type phase;
    logic [CNT_W-1:0] count;
    logic thermal_latch;
    logic [3:0] overload_latch;
    logic [1:0] mode;
    logic [31:0] prdata;
    logic fault_drive;
    logic warn_drive;
    logic [3:0] bridge_en;
    logic [3:0] high_en;
    logic test_gnd;
    logic test_sup;
  } psfm_state_type;

  psfm_state_type r_reg;
  psfm_state_type r_next;

  function automatic logic [3:0] group_stop(input logic [1:0] mode,
                                            input logic [3:0] f);
    if (mode == psfm_pkg::MODE_PARALLEL) begin
      group_stop = {4{|f}};
    end else begin
      group_stop = {{2{|f[3:2]}}, {2{|f[1:0]}}};
    end
  endfunction : group_stop

  function automatic logic reg_known(input logic [11:0] a);
    reg_known = (a == psfm_pkg::CONFIG_OFS) || (a == psfm_pkg::STATUS_OFS);
  endfunction : reg_known

  // ----------------------------------------------------------------
  // synchronised views
  // ----------------------------------------------------------------
  logic [psfm_pkg::IN_W-1:0] raw_in;
  logic rst_ok;
  logic warn_in;
  logic shut_in;
  logic sup_any;
  logic gnd_short;
  logic sup_short;
  logic [3:0] boot_low;
  logic [3:0] ovl_in;
  logic [3:0] stuck_in;
  logic [31:0] status_word;
  logic apb_setup;
  logic apb_access;

  assign raw_in = {temp_warning_n_i, shutdown_flag_n_i, pwm_stuck_cmp,
                   overload_cmp, boot_low_cmp, short_sup_cmp,
                   short_gnd_cmp, supply_low_cmp, ot_shut_cmp,
                   ot_warn_cmp, reset_pin_n};
  assign rst_ok = r_reg.sync2[psfm_pkg::IN_RST];
  assign warn_in = r_reg.sync2[psfm_pkg::IN_WARN];
  assign shut_in = r_reg.sync2[psfm_pkg::IN_SHUT];
  assign sup_any = |r_reg.sync2[psfm_pkg::IN_SUP +: 3];
  assign gnd_short = r_reg.sync2[psfm_pkg::IN_GSHORT];
  assign sup_short = r_reg.sync2[psfm_pkg::IN_PSHORT];
  assign boot_low = r_reg.sync2[psfm_pkg::IN_BOOT +: 4];
  assign ovl_in = r_reg.sync2[psfm_pkg::IN_OVL +: 4];
  assign stuck_in = r_reg.sync2[psfm_pkg::IN_STUCK +: 4];
  assign apb_setup = psel & ~penable;
  assign apb_access = psel & penable;

  always_comb begin
    status_word = 32'h0;
    status_word[psfm_pkg::ST_FAULT] = r_reg.fault_drive;
    status_word[psfm_pkg::ST_WARN] = r_reg.warn_drive;
    status_word[psfm_pkg::ST_THERM] = r_reg.thermal_latch;
    status_word[psfm_pkg::ST_SUPLOW] = sup_any;
    status_word[psfm_pkg::ST_OVL +: 4] = r_reg.overload_latch;
    status_word[psfm_pkg::ST_STUCK +: 4] = stuck_in;
    status_word[psfm_pkg::ST_BRIDGE +: 4] = r_reg.bridge_en;
    status_word[psfm_pkg::ST_BOOT +: 4] = boot_low;
    status_word[psfm_pkg::ST_PHASE +: 4] = r_reg.phase;
    status_word[psfm_pkg::ST_FLAG_PIN] =
      r_reg.sync2[psfm_pkg::IN_FLAG_PIN];
    status_word[psfm_pkg::ST_WARN_PIN] =
      r_reg.sync2[psfm_pkg::IN_WARN_PIN];
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic checking;
  logic run_ok;
  logic [3:0] stop;

  always_comb begin
    r_next = r_reg;
    checking = 1'b0;
    run_ok = 1'b0;
    stop = 4'h0;
    r_next.sync1 = raw_in;                 // [RULE_26]
    r_next.sync2 = r_reg.sync1;            // [RULE_26]

    // start-up and pin short check; a reset pin change never enters here
    unique case (r_reg.phase)
      psfm_pkg::PH_POWERUP: begin
        r_next.overload_latch = 4'h0;      // [RULE_14]
        r_next.count = '0;
        if (!sup_any) begin                // [RULE_14]
          if (r_reg.mode == psfm_pkg::MODE_SINGLE) begin
            r_next.phase = psfm_pkg::PH_RUN;   // [RULE_10]
          end else begin
            r_next.phase = psfm_pkg::PH_GND;   // [RULE_07]
          end
        end
      end
      psfm_pkg::PH_GND: begin
        if (sup_any) begin
          r_next.phase = psfm_pkg::PH_POWERUP;
        end else if (gnd_short) begin
          r_next.count = '0;               // [RULE_06]
        end else if (r_reg.count == STEP_LAST) begin
          r_next.count = '0;
          r_next.phase = psfm_pkg::PH_SUPPLY;  // [RULE_07]
        end else begin
          r_next.count = r_reg.count + 1'b1;
        end
      end
      psfm_pkg::PH_SUPPLY: begin
        if (sup_any) begin
          r_next.phase = psfm_pkg::PH_POWERUP;
        end else if (sup_short) begin
          r_next.count = '0;               // [RULE_06]
        end else if (r_reg.count == STEP_LAST) begin
          r_next.count = '0;
          r_next.phase = psfm_pkg::PH_RUN;
        end else begin
          r_next.count = r_reg.count + 1'b1;
        end
      end
      psfm_pkg::PH_RUN: begin
        // once running the check is never entered again
        r_next.phase = psfm_pkg::PH_RUN;   // [RULE_05] [RULE_09]
      end
      default: begin
        r_next.phase = psfm_pkg::PH_POWERUP;
      end
    endcase

    checking = (r_reg.phase == psfm_pkg::PH_GND) ||
               (r_reg.phase == psfm_pkg::PH_SUPPLY);
    r_next.test_gnd = (r_reg.phase == psfm_pkg::PH_GND);
    r_next.test_sup = (r_reg.phase == psfm_pkg::PH_SUPPLY);

    // latches: a new event wins over a clear in the same cycle
    r_next.thermal_latch = shut_in | // [RULE_12]
                           (r_reg.thermal_latch & rst_ok); // [RULE_13]
    if (r_reg.phase == psfm_pkg::PH_RUN) begin
      r_next.overload_latch = ovl_in |
                              (r_reg.overload_latch & {4{rst_ok}});
    end

    // channel stops: overload latched, stuck PWM self clearing
    stop = group_stop(r_reg.mode, // [RULE_03] [RULE_20]
                      r_next.overload_latch | stuck_in); // [RULE_25]
    run_ok = (r_reg.phase == psfm_pkg::PH_RUN) && rst_ok && // [RULE_24]
             !sup_any && !r_next.thermal_latch; // [RULE_15] [RULE_19]
    r_next.bridge_en = run_ok ? ~stop : 4'h0; // [RULE_01] [RULE_02]
    r_next.high_en = r_next.bridge_en & ~boot_low; // [RULE_04]

    // flag pulled low: check, thermal, overload, supply; reset forces high outside the check
    r_next.fault_drive = checking |                  // [RULE_08]
      (rst_ok & (r_next.thermal_latch |              // [RULE_16]
                 (|r_next.overload_latch) | sup_any)); // [RULE_15]
    r_next.warn_drive = warn_in | r_next.thermal_latch; // [RULE_11] [RULE_18]

    // registers; read data captured in setup, so it is a setup snapshot
    if (apb_setup) begin
      if (paddr == psfm_pkg::CONFIG_OFS) begin
        r_next.prdata = {30'h0, r_reg.mode};
      end else if (paddr == psfm_pkg::STATUS_OFS) begin
        r_next.prdata = status_word;
      end else begin
        r_next.prdata = 32'h0;
      end
    end
    if (apb_access && pwrite && pstrb[0] &&
        paddr == psfm_pkg::CONFIG_OFS) begin
      r_next.mode = pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg.sync1 <= SYNC_INIT; // [RULE_14]
      r_reg.sync2 <= SYNC_INIT; // [RULE_14]
      r_reg.phase <= psfm_pkg::PH_POWERUP;
      r_reg.count <= '0;
      r_reg.thermal_latch <= 1'b0;
      r_reg.overload_latch <= 4'h0;
      r_reg.mode <= psfm_pkg::CONFIG_RESET;
      r_reg.prdata <= 32'h0;
      r_reg.fault_drive <= 1'b0;
      r_reg.warn_drive <= 1'b0;
      r_reg.bridge_en <= 4'h0;
      r_reg.high_en <= 4'h0;
      r_reg.test_gnd <= 1'b0;
      r_reg.test_sup <= 1'b0;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata = r_reg.prdata;
  assign pready = 1'b1;
  assign pslverr = apb_access & ~reg_known(paddr);
  assign bridge_en = r_reg.bridge_en;
  assign high_side_en = r_reg.high_en;
  assign test_gnd_en = r_reg.test_gnd;
  assign test_sup_en = r_reg.test_sup;
  // open drain: only ever pull low, the pull-up sits outside
  assign shutdown_flag_n_o = 1'b0;               // [RULE_17]
  assign shutdown_flag_n_oe = r_reg.fault_drive; // [RULE_17]
  assign temp_warning_n_o = 1'b0;                // [RULE_17]
  assign temp_warning_n_oe = r_reg.warn_drive;   // [RULE_17]

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_thermal_off;
    r_reg.thermal_latch |-> r_reg.bridge_en == 4'h0 && r_reg.high_en == 4'h0;
  endproperty
  a_thermal_off: assert property (p_thermal_off) // [RULE_01] [RULE_12]
    else $error("bridges on during thermal shutdown");

  property p_self_clear;
    r_reg.phase == psfm_pkg::PH_RUN && rst_ok && !sup_any && !shut_in &&
    !r_reg.thermal_latch && r_reg.overload_latch == 4'h0 &&
    ovl_in == 4'h0 && stuck_in == 4'h0 |=> r_reg.bridge_en == 4'hf;
  endproperty
  a_self_clear: assert property (p_self_clear) // [RULE_02]
    else $error("bridges did not resume after fault cleared");

  property p_group_pair;
    r_reg.mode != psfm_pkg::MODE_PARALLEL && r_reg.overload_latch[1]
    |-> r_reg.bridge_en[1:0] == 2'h0;
  endproperty
  a_group_pair: assert property (p_group_pair) // [RULE_03] [RULE_20]
    else $error("pair not stopped on channel fault");

  property p_group_all;
    r_reg.mode == psfm_pkg::MODE_PARALLEL && stuck_in[2] &&
    $stable(r_reg.mode) |=> r_reg.bridge_en == 4'h0;
  endproperty
  a_group_all: assert property (p_group_all) // [RULE_03] [RULE_25]
    else $error("parallel mode did not stop all channels");

  property p_boot;
    boot_low[0] |=> !r_reg.high_en[0];
  endproperty
  a_boot: assert property (p_boot) // [RULE_04]
    else $error("high side on with bootstrap low");

  property p_check_hold;
    r_reg.phase == psfm_pkg::PH_GND ##1 r_reg.phase == psfm_pkg::PH_GND
    |-> r_reg.fault_drive && r_reg.bridge_en == 4'h0;
  endproperty
  a_check_hold: assert property (p_check_hold) // [RULE_06] [RULE_08]
    else $error("check running without flag or with bridges on");

  property p_once;
    r_reg.phase == psfm_pkg::PH_RUN |=> r_reg.phase == psfm_pkg::PH_RUN;
  endproperty
  a_once: assert property (p_once) // [RULE_05] [RULE_09]
    else $error("pin short check entered after start-up");

  property p_order;
    r_reg.phase == psfm_pkg::PH_SUPPLY |->
      $past(r_reg.phase) inside {psfm_pkg::PH_GND, psfm_pkg::PH_SUPPLY};
  endproperty
  a_order: assert property (p_order) // [RULE_07]
    else $error("supply step not preceded by ground step");

  property p_se_skip;
    r_reg.phase == psfm_pkg::PH_POWERUP && !sup_any &&
    r_reg.mode == psfm_pkg::MODE_SINGLE |=> r_reg.phase == psfm_pkg::PH_RUN;
  endproperty
  a_se_skip: assert property (p_se_skip) // [RULE_10]
    else $error("check not skipped in single-ended mode");

  property p_warn;
    warn_in |=> r_reg.warn_drive;
  endproperty
  a_warn: assert property (p_warn) // [RULE_11]
    else $error("warning not signalled");

  property p_therm_clear;
    r_reg.thermal_latch && !rst_ok && !shut_in |=> !r_reg.thermal_latch;
  endproperty
  a_therm_clear: assert property (p_therm_clear) // [RULE_13]
    else $error("thermal latch not cleared by reset pin");

  property p_therm_hold;
    r_reg.thermal_latch && rst_ok |=> r_reg.thermal_latch;
  endproperty
  a_therm_hold: assert property (p_therm_hold) // [RULE_13] [RULE_19]
    else $error("thermal latch dropped without reset");

  property p_por_clear;
    r_reg.phase == psfm_pkg::PH_POWERUP |=> r_reg.overload_latch == 4'h0;
  endproperty
  a_por_clear: assert property (p_por_clear) // [RULE_14]
    else $error("overload latch not cleared at power-up");

  property p_supply;
    r_reg.phase == psfm_pkg::PH_RUN && sup_any && rst_ok
    |=> r_reg.bridge_en == 4'h0 && r_reg.fault_drive;
  endproperty
  a_supply: assert property (p_supply) // [RULE_15]
    else $error("supply low not handled");

  property p_reset_flag;
    r_reg.phase == psfm_pkg::PH_RUN && !rst_ok
    |=> !r_reg.fault_drive && r_reg.bridge_en == 4'h0;
  endproperty
  a_reset_flag: assert property (p_reset_flag) // [RULE_16] [RULE_24]
    else $error("reset pin low did not release flag or stop bridges");

  property p_encoding;
    r_reg.phase == psfm_pkg::PH_RUN && rst_ok && shut_in
    |=> r_reg.fault_drive && r_reg.warn_drive;
  endproperty
  a_encoding: assert property (p_encoding) // [RULE_18]
    else $error("thermal shutdown not shown on both outputs");

  c_check_pass: cover property (r_reg.phase == psfm_pkg::PH_SUPPLY
                                ##1 r_reg.phase == psfm_pkg::PH_RUN);
  c_thermal_recover: cover property (r_reg.thermal_latch ##1
                                     !r_reg.thermal_latch);
  c_overload: cover property ($rose(|r_reg.overload_latch));
  c_short_held: cover property ((r_reg.phase == psfm_pkg::PH_GND &&
                                 gnd_short) [*3]);

endmodule : psfm_top

// ===== bench/psfm_ctrl.sv
`timescale 1ns/1ns
module psfm_ctrl #(
  parameter int HOLD_CYC = 16
) (
  input wire logic pclk,
  input wire logic rst_req,
  input wire logic flag_oe,
  input wire logic warn_oe,
  output logic reset_pin_n,
  output logic flag_n,
  output logic warn_n
);
  // hold after flag fall scaled down so the run stays short
  int gap = HOLD_CYC;
  logic flag_prev = 1'b1;
  logic pin_q = 1'b0;
  assign reset_pin_n = pin_q;
  // open-drain lines with pull-ups
  assign flag_n = flag_oe ? 1'b0 : 1'b1;
  assign warn_n = warn_oe ? 1'b0 : 1'b1;
  always @(posedge pclk) begin
    flag_prev <= flag_n;
    if (flag_prev && !flag_n) begin
      gap <= 0;
    end else if (gap < HOLD_CYC) begin
      gap <= gap + 1;
    end
    if (rst_req) begin
      pin_q <= 1'b0;
    end else if (warn_n && gap >= HOLD_CYC) begin
      pin_q <= 1'b1;
    end
  end
endmodule : psfm_ctrl

// ===== bench/tb.sv
`timescale 1ns/1ns
module tb;
  logic pclk, presetn, psel, penable, pwrite, rst_req, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, lf;
  logic [3:0] pstrb, boot_low_cmp, overload_cmp, pwm_stuck_cmp, br;
  logic [3:0] bridge_en, high_side_en;
  logic [2:0] supply_low_cmp;
  logic [1:0] m;
  logic pready, pslverr, reset_pin_n, ot_warn_cmp, ot_shut_cmp;
  logic short_gnd_cmp, short_sup_cmp, test_gnd_en, test_sup_en;
  logic flag_n, flag_oe, warn_n, warn_oe;
  int n_mismatch = 0;
  int n_tests = 0;
  int n_gnd = 0;
  int g0 = 0;

  psfm_top #(.STEP_CYCLES(8)) dut (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reset_pin_n(reset_pin_n),
    .ot_warn_cmp(ot_warn_cmp), .ot_shut_cmp(ot_shut_cmp),
    .supply_low_cmp(supply_low_cmp), .short_gnd_cmp(short_gnd_cmp),
    .short_sup_cmp(short_sup_cmp), .boot_low_cmp(boot_low_cmp),
    .overload_cmp(overload_cmp), .pwm_stuck_cmp(pwm_stuck_cmp),
    .bridge_en(bridge_en), .high_side_en(high_side_en),
    .test_gnd_en(test_gnd_en), .test_sup_en(test_sup_en),
    .shutdown_flag_n_i(flag_n), .shutdown_flag_n_o(),
    .shutdown_flag_n_oe(flag_oe), .temp_warning_n_i(warn_n),
    .temp_warning_n_o(), .temp_warning_n_oe(warn_oe));

  psfm_ctrl #(.HOLD_CYC(16)) ctrl (.pclk(pclk), .rst_req(rst_req),
    .flag_oe(flag_oe), .warn_oe(warn_oe), .reset_pin_n(reset_pin_n),
    .flag_n(flag_n), .warn_n(warn_n));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // counts ground-step cycles: a later check shows up as growth
  always @(posedge pclk) begin
    if (test_gnd_en === 1'b1) n_gnd <= n_gnd + 1;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // channel group stopped by a fault on one channel
  function automatic logic [3:0] grp(input logic [1:0] md, input int ch);
    if (md == psfm_pkg::MODE_PARALLEL) return 4'hf;
    return (ch < 2) ? 4'h3 : 4'hc;
  endfunction : grp

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic stop_test;
    $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  // controller flop, two sync flops, output flop, then a settled look
  task automatic settle;
    repeat (5) @(posedge pclk);
  endtask : settle

  task automatic wt(input int k);
    int n = 0;
    while (!(k == 0 ? test_gnd_en === 1'b1 : k == 1 ? test_sup_en === 1'b1
        : k == 2 ? bridge_en === 4'hf : reset_pin_n === 1'b1) && n < 300) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 300) begin
      n_mismatch++;
      stop_test;
    end
  endtask : wt

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      n_mismatch++;
      stop_test;
    end
  endtask : apb

  // supply power-up: supplies low while the mode is written
  task automatic pu(input logic [1:0] md);
    presetn <= 1'b0;
    supply_low_cmp <= 3'h7;
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, psfm_pkg::CONFIG_OFS, {30'h0, md});
    supply_low_cmp <= 3'h0;
  endtask : pu

  task automatic rtog;
    rst_req <= 1'b1;
    settle;
    rst_req <= 1'b0;
    wt(3);
    settle;
  endtask : rtog

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, rst_req} = 4'h0;
    {ot_warn_cmp, ot_shut_cmp, short_sup_cmp} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    supply_low_cmp = 3'h7;
    short_gnd_cmp = 1'b1;
    {boot_low_cmp, overload_cmp, pwm_stuck_cmp} = 12'h000;
    lf = 32'd76724;
    @(posedge pclk);
    pu(psfm_pkg::MODE_BRIDGED);
    wt(0);
    rst_req <= 1'b1;
    repeat (30) @(posedge pclk);
    chk({test_gnd_en, flag_oe, bridge_en}, 6'h30);
    rst_req <= 1'b0;
    short_gnd_cmp <= 1'b0;
    short_sup_cmp <= 1'b1;
    wt(1);
    chk({test_gnd_en, flag_oe}, 2'h1);
    repeat (12) @(posedge pclk);
    chk({test_sup_en, flag_oe, bridge_en}, 6'h30);
    short_sup_cmp <= 1'b0;
    wt(2);
    chk(flag_oe, 1'b0);
    $display("test startup done");
    g0 = n_gnd;
    rst_req <= 1'b1;
    settle;
    chk({flag_oe, bridge_en}, 5'h00);
    rst_req <= 1'b0;
    wt(3);
    settle;
    chk(n_gnd - g0, 0);
    chk(bridge_en, 4'hf);
    $display("test reset pin done");
    for (int i = 0; i < 12; i++) begin
      lf = lfsr(lf);
      m = lf[1:0];
      apb(1'b1, psfm_pkg::CONFIG_OFS, {30'h0, m});
      pwm_stuck_cmp <= 4'h1 << lf[3:2];
      boot_low_cmp <= lf[7:4];
      settle;
      br = 4'hf & ~grp(m, int'(lf[3:2]));
      chk(bridge_en, br);
      chk(high_side_en, br & ~lf[7:4]);
      chk(flag_oe, 1'b0);
      {pwm_stuck_cmp, boot_low_cmp} <= 8'h00;
      settle;
      chk(bridge_en, 4'hf);
    end
    $display("test channel groups done");
    apb(1'b1, psfm_pkg::CONFIG_OFS, 32'h0);
    overload_cmp <= 4'h4;
    repeat (2) @(posedge pclk);
    overload_cmp <= 4'h0;
    settle;
    chk({flag_oe, warn_oe, bridge_en}, 6'h23);
    rtog;
    chk(bridge_en, 4'hf);
    ot_warn_cmp <= 1'b1;
    settle;
    chk({flag_oe, warn_oe, bridge_en}, 6'h1f);
    ot_shut_cmp <= 1'b1;
    settle;
    chk({flag_oe, warn_oe, bridge_en}, 6'h30);
    {ot_shut_cmp, ot_warn_cmp} <= 2'h0;
    settle;
    chk({flag_oe, bridge_en}, 5'h10);
    rtog;
    chk(bridge_en, 4'hf);
    $display("test thermal done");
    lf = lfsr(lf);
    supply_low_cmp <= {lf[1:0], 1'b1};
    settle;
    chk({flag_oe, bridge_en}, 5'h10);
    supply_low_cmp <= 3'h0;
    settle;
    chk({flag_oe, bridge_en}, 5'h0f);
    apb(1'b0, psfm_pkg::STATUS_OFS, 32'h0);
    chk(rd, (32'h3 << psfm_pkg::ST_FLAG_PIN) |
      (32'h8 << psfm_pkg::ST_PHASE) | (32'hf << psfm_pkg::ST_BRIDGE));
    apb(1'b0, 12'h008, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    $display("test supply done");
    g0 = n_gnd;
    pu(psfm_pkg::MODE_SINGLE);
    wt(2);
    chk(n_gnd - g0, 0);
    apb(1'b0, psfm_pkg::CONFIG_OFS, 32'h0);
    chk(rd, {30'h0, psfm_pkg::MODE_SINGLE});
    $display("test single ended done");
    stop_test;
  end
endmodule : tb
